// File: udt_pin_model.sv
// Model of the event source, direction pin and watch clock at the timer's far side
`timescale 1ns/10ps
module udt_pin_model
(
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [7:0] nPulse,
  input  wire logic       slow,
  input  wire logic       dirLevel,
  output logic            eventInputPin,
  output logic            directionPin,
  output logic            watchClkDiv4,
  output logic            busy
);
  int w;
  initial
  begin
    eventInputPin = 1'b0;
    watchClkDiv4  = 1'b0;
    busy          = 1'b0;
  end
  assign directionPin = dirLevel;
  // Watch clock runs free, unrelated to the system clock
  always #150 watchClkDiv4 = ~watchClkDiv4;
  // Burst of event pulses, prompt or slow, idle low between bursts
  always @(posedge ref_clk)
  begin
    if (go)
    begin
      busy <= 1'b1;
      w = slow ? 17 : 5;
      repeat (nPulse)
      begin
        repeat (w) @(posedge ref_clk);
        eventInputPin <= 1'b1;
        repeat (w) @(posedge ref_clk);
        eventInputPin <= 1'b0;
      end
      repeat (8) @(posedge ref_clk);
      busy <= 1'b0;
    end
  end
endmodule

// File: udt_pkg.sv
// Constants shared by the up/down interval and auto-reload timer
package udt_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 32;
  localparam logic [3:0]  OFFS_MODE   = 4'h0;
  localparam logic [3:0]  OFFS_COUNT  = 4'h4;
  localparam logic [3:0]  OFFS_IRQ    = 4'h8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Mode register layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  MODE_RESET      = 8'h18;
  localparam logic [7:0]  MODE_RSV_MASK   = 8'h18;
  localparam int          MODE_RELOAD_BIT = 7;
  localparam int          MODE_HWDIR_BIT  = 6;
  localparam int          MODE_SWDIR_BIT  = 5;
  localparam int          MODE_CKSEL_LSB  = 0;
  localparam int          CKSEL_W         = 3;

  // ----------------------------------------------------------------
  // Clock select codes and prescaler taps
  // ----------------------------------------------------------------
  localparam logic [2:0]  CKS_DIV8192  = 3'h0;
  localparam logic [2:0]  CKS_DIV2048  = 3'h1;
  localparam logic [2:0]  CKS_DIV512   = 3'h2;
  localparam logic [2:0]  CKS_DIV64    = 3'h3;
  localparam logic [2:0]  CKS_DIV16    = 3'h4;
  localparam logic [2:0]  CKS_DIV4     = 3'h5;
  localparam logic [2:0]  CKS_WATCH4   = 3'h6;
  localparam logic [2:0]  CKS_EVENT    = 3'h7;
  localparam int          NUM_TAPS     = 6;
  localparam int          PRE_W        = 13;
  localparam int          DIV_LOG2 [NUM_TAPS] = '{13, 11, 9, 6, 4, 2};

  // ----------------------------------------------------------------
  // Counter and interrupt register
  // ----------------------------------------------------------------
  localparam logic [7:0]  COUNT_RESET  = 8'h00;
  localparam logic [7:0]  RELOAD_RESET = 8'h00;
  localparam logic [7:0]  COUNT_MAX    = 8'hff;
  localparam logic [7:0]  COUNT_MIN    = 8'h00;
  localparam logic [7:0]  STEP_FULL    = 8'h01;
  localparam logic [7:0]  STEP_HALF    = 8'h02;
  localparam int          IRQ_FLAG_BIT = 0;
  localparam int          IRQ_EN_BIT   = 1;

endpackage

// File: udt_sync3.sv
// Three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module udt_sync3
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic stage1R;
  logic stage2R;
  logic stage3R;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      stage1R <= 1'b0;
      stage2R <= 1'b0;
      stage3R <= 1'b0;
    end
    else
    begin
      stage1R <= din;
      stage2R <= stage1R;
      stage3R <= stage2R;
    end
  end

  // ----------------------------------------------------------------
  // A change counts once stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end
    else
    begin
      rise <= (stage2R == stage3R) && stage3R && !level;
      fall <= (stage2R == stage3R) && !stage3R && level;
      if (stage2R == stage3R)
      begin
        level <= stage3R;
      end
    end
  end

endmodule

// File: udt_timer.sv
// Eight-bit up/down interval and auto-reload timer with AXI4-Lite registers
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
// How it works
// - Reload-mode bit low runs the counter as a free 8-bit interval timer.
// - Reset clears the counter and sets the mode register to 0x18.
// - Count clock comes from six internal prescaled clocks, the watch clock over four or the event pin.
// - Direction is set by software mode bits or by the direction pin.
// - Count at max going up or zero going down sets the irq flag.
// - Interrupt output goes high one clock after flag and enable are both set, and drops one clock after either clears.
// - Interval mode wraps to zero or to max and keeps its direction.
// - Interval mode copies a load-register write into the counter at once.
// - Reload mode loads the reload value on every overflow or underflow.
// - Reload value sets the wrap period anywhere from 1 to 256 clocks.
// - Reload mode also copies a load-register write straight into the counter.
// - Clock select 111 counts on the chosen edge of the event pin.
// - With hardware direction, pin high counts down and pin low counts up.
// - In low-speed states only event or watch/4 sources advance the counter.
// - In low-speed state, watch/4 with subclock at watch/8 steps the counter by two, so bit 0 changes only on a wrap or a load.
// - Watch/4 source is synchronised to the system clock first.
// - Codes 0-5 give system clock over 8192..4, 6 watch/4, 7 event.
// - Direction bits 00 up, 01 down, 1x hands control to the pin.
// - Counter reads and load-register writes share one address.
// - Mode register bits 4 and 3 always read as one and ignore writes.
module udt_timer
#(
  parameter int PRESC_LOG2 = 13
)
(
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic [udt_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [udt_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [udt_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [udt_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         eventInputPin,
  input  wire logic                         eventEdgeRising,
  input  wire logic                         directionPin,
  input  wire logic                         watchClkDiv4,
  input  wire logic                         lowSpeedMode,
  input  wire logic                         subclockDiv8,
  input  wire logic                         counterHalt,
  output logic                              timerIrq
);

  logic [7:0]                  modeR;
  logic [7:0]                  countR;
  logic [7:0]                  countNxt;
  logic [7:0]                  reloadR;
  logic                        irqFlagR;
  logic                        irqEnR;
  logic [udt_pkg::PRE_W-1:0]   preR;
  logic [udt_pkg::NUM_TAPS-1:0] tapR;
  logic                        awHeldR;
  logic                        wHeldR;
  logic [udt_pkg::ADDR_W-1:0]  awAddrR;
  logic [7:0]                  wDataR;
  logic                        wLane0R;
  logic                        wrExec;
  logic                        loadWr;
  logic                        modeWr;
  logic                        irqWr;
  logic                        wrMapped;
  logic                        evLevel;
  logic                        evRise;
  logic                        evFall;
  logic                        dirLevel;
  logic                        wcRise;
  logic [2:0]                  clkSel;
  logic                        reloadMode;
  logic                        countUp;
  logic                        halfRate;
  logic [7:0]                  stepV;
  logic                        srcTick;
  logic                        countTick;
  logic                        wrap;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  udt_sync3 u_evSync
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (eventInputPin),
    .level   (evLevel),
    .rise    (evRise),
    .fall    (evFall)
  );

  udt_sync3 u_dirSync
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (directionPin),
    .level   (dirLevel),
    .rise    (),
    .fall    ()
  );

  udt_sync3 u_wcSync
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (watchClkDiv4),
    .level   (),
    .rise    (wcRise),
    .fall    ()
  );

  // ----------------------------------------------------------------
  // Prescaler and its tap pulses
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      preR <= '0;
    else
      preR <= preR + 1'b1;
  end

  for (genvar i = 0; i < udt_pkg::NUM_TAPS; i++)
  begin : g_tap
    localparam int TAP_LOG2 = (i == 0) ? PRESC_LOG2 : udt_pkg::DIV_LOG2[i];
    localparam logic [udt_pkg::PRE_W-1:0] TAP_MASK = udt_pkg::PRE_W'((1 << TAP_LOG2) - 1);
    always_ff @(posedge ref_clk)
    begin
      if (rst)
        tapR[i] <= 1'b0;
      else
        tapR[i] <= ((preR & TAP_MASK) == TAP_MASK);
    end
  end

  // ----------------------------------------------------------------
  // Clock source, direction and step
  // ----------------------------------------------------------------
  assign clkSel     = modeR[udt_pkg::MODE_CKSEL_LSB +: udt_pkg::CKSEL_W];
  assign reloadMode = modeR[udt_pkg::MODE_RELOAD_BIT];
  assign countUp    = modeR[udt_pkg::MODE_HWDIR_BIT] ? !dirLevel : !modeR[udt_pkg::MODE_SWDIR_BIT];
  assign halfRate   = lowSpeedMode && subclockDiv8 && (clkSel == udt_pkg::CKS_WATCH4);
  assign stepV      = halfRate ? udt_pkg::STEP_HALF : udt_pkg::STEP_FULL;

  always_comb
  begin
    unique case (clkSel)
      udt_pkg::CKS_DIV8192: srcTick = tapR[0] && !lowSpeedMode;
      udt_pkg::CKS_DIV2048: srcTick = tapR[1] && !lowSpeedMode;
      udt_pkg::CKS_DIV512:  srcTick = tapR[2] && !lowSpeedMode;
      udt_pkg::CKS_DIV64:   srcTick = tapR[3] && !lowSpeedMode;
      udt_pkg::CKS_DIV16:   srcTick = tapR[4] && !lowSpeedMode;
      udt_pkg::CKS_DIV4:    srcTick = tapR[5] && !lowSpeedMode;
      udt_pkg::CKS_WATCH4:  srcTick = wcRise;
      udt_pkg::CKS_EVENT:   srcTick = eventEdgeRising ? evRise : evFall;
    endcase
  end

  assign countTick = srcTick && !counterHalt;
  assign wrap      = countUp ? (countR > (udt_pkg::COUNT_MAX - stepV)) : (countR < stepV);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb
  begin
    countNxt = countR;
    if (loadWr)
      countNxt = wDataR;
    else if (countTick && wrap && reloadMode)
      countNxt = reloadR;
    else if (countTick && wrap)
      countNxt = countUp ? udt_pkg::COUNT_MIN : udt_pkg::COUNT_MAX;
    else if (countTick)
      countNxt = countUp ? countR + stepV : countR - stepV;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      countR <= udt_pkg::COUNT_RESET;
    else
      countR <= countNxt;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      reloadR <= udt_pkg::RELOAD_RESET;
    else if (loadWr)
      reloadR <= wDataR;
  end

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      modeR <= udt_pkg::MODE_RESET;
    else if (modeWr)
      modeR <= (wDataR & ~udt_pkg::MODE_RSV_MASK) | udt_pkg::MODE_RSV_MASK;
  end

  // ----------------------------------------------------------------
  // Interrupt flag, enable and request
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      irqFlagR <= 1'b0;
    else if (countTick && wrap)
      irqFlagR <= 1'b1;
    else if (irqWr && wDataR[udt_pkg::IRQ_FLAG_BIT])
      irqFlagR <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      irqEnR <= 1'b0;
    else if (irqWr)
      irqEnR <= wDataR[udt_pkg::IRQ_EN_BIT];
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      timerIrq <= 1'b0;
    else
      timerIrq <= irqFlagR && irqEnR;
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  assign wrExec   = awHeldR && wHeldR && !s_axi_bvalid;
  assign wrMapped = (awAddrR == udt_pkg::OFFS_MODE) || (awAddrR == udt_pkg::OFFS_COUNT) ||
                    (awAddrR == udt_pkg::OFFS_IRQ);
  assign loadWr   = wrExec && wLane0R && (awAddrR == udt_pkg::OFFS_COUNT);
  assign modeWr   = wrExec && wLane0R && (awAddrR == udt_pkg::OFFS_MODE);
  assign irqWr    = wrExec && wLane0R && (awAddrR == udt_pkg::OFFS_IRQ);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      awHeldR       <= 1'b0;
      awAddrR       <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      awHeldR       <= 1'b1;
      awAddrR       <= {s_axi_awaddr[udt_pkg::ADDR_W-1:2], 2'h0};
    end
    else if (s_axi_bvalid && s_axi_bready)
      awHeldR <= 1'b0;
    else if (!awHeldR)
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_wready <= 1'b0;
      wHeldR       <= 1'b0;
      wDataR       <= '0;
      wLane0R      <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      wHeldR       <= 1'b1;
      wDataR       <= s_axi_wdata[7:0];
      wLane0R      <= s_axi_wstrb[0];
    end
    else if (s_axi_bvalid && s_axi_bready)
      wHeldR <= 1'b0;
    else if (!wHeldR)
      s_axi_wready <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= udt_pkg::RESP_OKAY;
    end
    else if (wrExec)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrMapped ? udt_pkg::RESP_OKAY : udt_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      s_axi_arready <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready)
      s_axi_arready <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= udt_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= udt_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[udt_pkg::ADDR_W-1:2], 2'h0})
        udt_pkg::OFFS_MODE:  s_axi_rdata <= {24'h000000, modeR};
        udt_pkg::OFFS_COUNT: s_axi_rdata <= {24'h000000, countR};
        udt_pkg::OFFS_IRQ:   s_axi_rdata <= {30'h0, irqEnR, irqFlagR};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= udt_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_RESET_STATE: assert property (@(posedge ref_clk) rst |=> (modeR == udt_pkg::MODE_RESET) &&
    (countR == udt_pkg::COUNT_RESET))
    else $error("reset did not set mode and counter");

  AST_IRQ_OUT: assert property (@(posedge ref_clk) disable iff (rst)
    (irqFlagR && irqEnR) |=> timerIrq)
    else $error("interrupt output missing while flag and enable set");

  AST_IRQ_QUIET: assert property (@(posedge ref_clk) disable iff (rst)
    !(irqFlagR && irqEnR) |=> !timerIrq)
    else $error("interrupt output high without flag and enable");

  AST_WRAP_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
    (countTick && wrap) |=> irqFlagR)
    else $error("wrap did not set the interrupt flag");

  AST_INTERVAL_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
    (countTick && wrap && !reloadMode && !loadWr) |=>
    (countR == ($past(countUp) ? udt_pkg::COUNT_MIN : udt_pkg::COUNT_MAX)))
    else $error("interval wrap went to the wrong value");

  AST_AUTO_RELOAD: assert property (@(posedge ref_clk) disable iff (rst)
    (countTick && wrap && reloadMode && !loadWr) |=> (countR == $past(reloadR)))
    else $error("reload value not loaded on wrap");

  AST_LOAD_COPY: assert property (@(posedge ref_clk) disable iff (rst)
    loadWr |=> (countR == $past(wDataR)) && (reloadR == $past(wDataR)) && s_axi_bvalid)
    else $error("load write not copied into counter");

  AST_RSV_BITS: assert property (@(posedge ref_clk) disable iff (rst)
    modeWr |=> ((modeR & udt_pkg::MODE_RSV_MASK) == udt_pkg::MODE_RSV_MASK))
    else $error("reserved mode bits not held at one");

  AST_LOWSPEED_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    (lowSpeedMode && (clkSel < udt_pkg::CKS_WATCH4) && !loadWr) |=> $stable(countR))
    else $error("counter moved on an internal source in low-speed state");

  AST_HW_DOWN: assert property (@(posedge ref_clk) disable iff (rst)
    (modeR[udt_pkg::MODE_HWDIR_BIT] && dirLevel && countTick && !wrap && !loadWr && !halfRate) |=>
    (countR == $past(countR) - 8'h01))
    else $error("pin high did not count down");

endmodule

// File: updown_interval_reload_timer_bench.sv
// Self-checking bench for the up/down interval and auto-reload timer
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module updown_interval_reload_timer_bench;
  localparam logic [3:0] AM = udt_pkg::OFFS_MODE;
  localparam logic [3:0] AC = udt_pkg::OFFS_COUNT;
  localparam logic [3:0] AI = udt_pkg::OFFS_IRQ;
  logic        ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, evPin, edgeRise, dirPin, watchClk;
  logic        lowSpeed, subDiv8, halt, timerIrq, go, slow, dirLevel, busy;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, seed, d;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  nPulse;
  int          errors, cmp_count, cyc, mCount, mRel, mMode, mFlag, mEn;
  logic [7:0]  tm [5] = '{8'h07, 8'ha7, 8'h87, 8'hc7, 8'hc7};
  logic [7:0]  tl [5] = '{8'hfd, 8'h03, 8'hff, 8'h01, 8'hfe};
  logic [7:0]  tn [5] = '{8'd5, 8'd6, 8'd3, 8'd3, 8'd3};
  logic        te [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic        td [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  int          cs [4] = '{0, 3, 4, 5};
  int          sh [4] = '{3, 6, 4, 2};

  udt_timer #(.PRESC_LOG2(3)) dut
  (
    .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .eventInputPin(evPin), .eventEdgeRising(edgeRise), .directionPin(dirPin),
    .watchClkDiv4(watchClk), .lowSpeedMode(lowSpeed), .subclockDiv8(subDiv8),
    .counterHalt(halt), .timerIrq(timerIrq)
  );
  udt_pin_model pins
  (
    .ref_clk(ref_clk), .go(go), .nPulse(nPulse), .slow(slow), .dirLevel(dirLevel),
    .eventInputPin(evPin), .directionPin(dirPin), .watchClkDiv4(watchClk), .busy(busy)
  );

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      errors++;
      final_report();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic final_report();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus tasks: sample and change at the rising edge, ready held high
  // ----------------------------------------------------------------
  task automatic axw(input logic [3:0] a, input logic [7:0] v);
    logic aw, w, b;
    int   n;
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b && n < 50)
    begin
      @(posedge ref_clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = (bvalid === 1'b1);
      r = bresp;
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      n++;
    end
    `CHK(b, 1'b1)
  endtask

  task automatic axr(input logic [3:0] a);
    logic ar, b;
    int   n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b && n < 50)
    begin
      @(posedge ref_clk);
      ar = arvalid & arready;
      b = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      if (ar) arvalid <= 1'b0;
      n++;
    end
    `CHK(b, 1'b1)
  endtask

  task automatic rchk(input logic [3:0] a, input int e, input logic [1:0] er);
    axr(a);
    `CHK(d, 32'(e))
    `CHK(r, er)
  endtask

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  task automatic mstep(input bit dn);
    if (dn ? mCount == 0 : mCount == 255)
    begin
      mFlag = 1;
      mCount = mMode[7] ? mRel : (dn ? 255 : 0);
    end
    else
      mCount = dn ? mCount - 1 : mCount + 1;
  endtask

  task automatic setMode(input logic [7:0] v);
    axw(AM, v);
    mMode = int'(v) | 'h18;
  endtask

  task automatic load(input logic [7:0] v);
    axw(AC, v);
    mRel = v;
    mCount = v;
  endtask

  task automatic window(input int c);
    halt <= 1'b0;
    repeat (c) @(posedge ref_clk);
    halt <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic pulses(input logic [7:0] n, input logic e, input bit dn);
    int k;
    seed = lfsr(seed);
    edgeRise <= e;
    nPulse <= n;
    slow <= seed[0];
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    k = 0;
    do
    begin
      @(negedge ref_clk);
      k++;
    end
    while (busy !== 1'b0 && k < 2000);
    @(posedge ref_clk);
    repeat (n) mstep(dn);
  endtask

  initial
  begin
    {ref_clk, awvalid, wvalid, bready, arvalid, rready, go, slow, dirLevel} = '0;
    {lowSpeed, subDiv8, awaddr, araddr, wdata, nPulse} = '0;
    {rst, halt, edgeRise} = 3'h7;
    wstrb = 4'hf;
    seed = 32'h6cfbb8cc;
    {errors, cmp_count, cyc, mCount, mRel, mFlag, mEn} = '0;
    mMode = 'h18;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rchk(AM, 'h18, udt_pkg::RESP_OKAY);
    rchk(AC, 0, udt_pkg::RESP_OKAY);
    rchk(AI, 0, udt_pkg::RESP_OKAY);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      setMode({seed[7:3], 3'(i)});
      rchk(AM, mMode, udt_pkg::RESP_OKAY);
      load(seed[15:8]);
      rchk(AC, mCount, udt_pkg::RESP_OKAY);
    end
    $display("mode and load test done");
    for (int i = 0; i < 4; i++)
    begin
      setMode(8'(cs[i]));
      load(8'h10);
      window(64);
      repeat (64 >> sh[i]) mstep(1'b0);
      rchk(AC, mCount, udt_pkg::RESP_OKAY);
    end
    setMode(8'h25);
    load(8'h02);
    window(16);
    repeat (4) mstep(1'b1);
    rchk(AC, mCount, udt_pkg::RESP_OKAY);
    rchk(AI, mFlag, udt_pkg::RESP_OKAY);
    axw(AI, 8'h02);
    mEn = 1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(timerIrq, 1'b1)
    @(posedge ref_clk);
    axw(AI, 8'h03);
    mFlag = 0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(timerIrq, 1'b0)
    @(posedge ref_clk);
    $display("prescaler and interrupt test done");
    for (int i = 0; i < 5; i++)
    begin
      dirLevel <= td[i];
      axw(AI, 8'h03);
      mFlag = 0;
      setMode(tm[i]);
      load(tl[i]);
      halt <= 1'b0;
      pulses(tn[i], te[i], tm[i][6] ? td[i] : tm[i][5]);
      rchk(AC, mCount, udt_pkg::RESP_OKAY);
      rchk(AI, mFlag + 2 * mEn, udt_pkg::RESP_OKAY);
    end
    $display("event test done");
    halt <= 1'b1;
    lowSpeed <= 1'b1;
    setMode(8'h05);
    load(8'h10);
    window(64);
    rchk(AC, mCount, udt_pkg::RESP_OKAY);
    subDiv8 <= 1'b1;
    setMode(8'h06);
    window(400);
    axr(AC);
    `CHK(d[0], 1'b0)
    `CHK(d[7:0] != 8'h10, 1'b1)
    {lowSpeed, subDiv8} <= 2'b00;
    $display("low speed test done");
    axw(4'hc, 8'h55);
    `CHK(r, udt_pkg::RESP_SLVERR)
    rchk(4'hc, 0, udt_pkg::RESP_SLVERR);
    $display("unmapped test done");
    final_report();
  end
endmodule
